// File: core/dll_cfg_consts.svh
// constants for the delay loop and datapath configuration register bank
// assumes: included by the package and the bank; offsets are register indices
`ifndef DLL_CFG_CONSTS_SVH
`define DLL_CFG_CONSTS_SVH

// ===========================================================================
// register indices and byte addresses (address = 4 x index)
`define IDX_PWR 12'h0_0C0
`define IDX_CTRL 12'h0_0C1
`define IDX_STAT 12'h0_0C3
`define IDX_READ 12'h0_0C7
`define IDX_FINE_A 12'h0_0CC
`define IDX_FINE_B 12'h0_0CD
`define IDX_UPD 12'h0_0DB
`define IDX_DIG 12'h0_100
`define IDX_LINK 12'h0_110
`define ADDR_OF(i) ((i) << 2)

// ===========================================================================
// field positions
`define PWR_DOWN_BIT 0
`define PWR_AUX_A_BIT 4
`define PWR_AUX_B_BIT 5
`define CTRL_EN_BIT 0
`define CTRL_MODE_BIT 5
`define LINK_MERGE_BIT 6
`define LINK_INVALID_BIT 7

// ===========================================================================
// reset values
`define RST_PWR_DOWN 1'h1
`define RST_AUX 1'h1
`define RST_CONV_SET 2'h1
`define RST_SEARCH_MODE 1'h1
`define RST_SEARCH_DIR 2'h2
`define RST_LOOP_EN 1'h0
`define RST_DIG_HOLD 1'h1
`define RST_LINK_MODE 6'h20
`define LINK_MODE_MAX 5'h16

`endif

// File: core/dll_cfg_pkg.sv
// types for the delay loop and datapath configuration register bank
// assumes: the constants header sits beside this file
package dll_cfg_pkg;
  `include "dll_cfg_consts.svh"

  // loop settings that reach the delay loop circuitry
  typedef struct packed {
    logic [1:0] conv_set;
    logic search_mode;
    logic [1:0] search_dir;
    logic [5:0] fine_a;
    logic [5:0] fine_b;
  } loop_cfg_t;

  // serial link selection seen by the link logic
  typedef struct packed {
    logic merge;
    logic dual;
    logic [4:0] mode;
  } link_cfg_t;

  // whole state of the bank
  typedef struct packed {
    logic pwr_down;
    logic aux_a;
    logic aux_b;
    logic loop_en;
    loop_cfg_t shadow;
    loop_cfg_t applied;
    logic read_en;
    logic update;
    logic lock_snap;
    logic dig_hold;
    logic merge;
    logic [5:0] link_mode;
    logic lock_meta;
    logic lock_sync;
    logic [1:0] sync_meta;
    logic [1:0] sync_sync;
    logic [1:0] sync_out;
    logic [31:0] rdata;
    logic err;
  } st_t;
endpackage

// File: core/dll_datapath_cfg.sv
// register bank for the delay-locked loop, digital datapath reset and link mode
// assumes: APB master on pclk; lock and link sync inputs arrive asynchronously;
// interpolation settings come from logic on the same clock
//
// Operation
// - power bit 0 powers down delay line
// - loop controller runs only when enabled
// - lock indicator reads one when locked
// - lock indicator refreshes on readback rising edge
// - loop settings applied on update rising edge
// - digital reset bit holds datapath logic
// - bit seven flags unsupported mode combination
// - merge sync outputs in dual link
// - bit five selects single or dual
// - low five bits select link mode
`include "dll_cfg_consts.svh"

module dll_datapath_cfg
  import dll_cfg_pkg::*;
(
  input wire logic pclk, // bank clock, 40 MHz
  input wire logic presetn, // asynchronous reset, low active
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high writes
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic dll_locked, // lock level from the delay loop
  input wire logic [3:0] dp_interp, // main datapath interpolation setting
  input wire logic [3:0] ch_interp, // channel interpolation setting
  input wire logic [1:0] link_sync_in, // per-link sync requests, low active
  output logic delay_line_power_down, // high powers down and bypasses line
  output logic delay_line_aux_power_a, // auxiliary power control a
  output logic delay_line_aux_power_b, // auxiliary power control b
  output logic loop_enable, // delay loop controller enable
  output loop_cfg_t loop_applied, // settings held by the loop circuitry
  output logic digital_logic_hold_reset, // high holds digital logic in reset
  output link_cfg_t link_mode_select, // link mode seen by the link logic
  output logic link_mode_invalid, // unsupported mode combination
  output logic [1:0] link_sync_output // sync outputs after merging
);

  // ===========================================================================
  // state
  st_t st_reg;
  st_t st_next;

  localparam st_t ST_RESET = '{
    pwr_down: `RST_PWR_DOWN,
    aux_a: `RST_AUX,
    aux_b: `RST_AUX,
    loop_en: `RST_LOOP_EN,
    shadow: '{conv_set: `RST_CONV_SET, search_mode: `RST_SEARCH_MODE,
      search_dir: `RST_SEARCH_DIR, fine_a: 6'h00, fine_b: 6'h00},
    applied: '{conv_set: `RST_CONV_SET, search_mode: `RST_SEARCH_MODE,
      search_dir: `RST_SEARCH_DIR, fine_a: 6'h00, fine_b: 6'h00},
    read_en: 1'h0,
    update: 1'h0,
    lock_snap: 1'h0,
    dig_hold: `RST_DIG_HOLD,
    merge: 1'h0,
    link_mode: `RST_LINK_MODE,
    lock_meta: 1'h0,
    lock_sync: 1'h0,
    sync_meta: 2'h3,
    sync_sync: 2'h3,
    sync_out: 2'h3,
    rdata: 32'h0000_0000,
    err: 1'h0
  };

  // ===========================================================================
  // bus phases
  logic setup_cyc;
  logic wr_cyc;
  logic hit;
  logic [7:0] rd_byte;
  logic merged;
  logic readback_rise;
  logic update_rise;

  // setup latches read data, access phase commits writes
  assign setup_cyc = psel && !penable;
  assign wr_cyc = psel && penable && pwrite;
  assign pready = 1'b1; // zero wait states

  // invalid combination check on live settings
  always_comb begin
    logic dp_ok;
    logic ch_ok;
    dp_ok = 1'b0;
    ch_ok = 1'b0;
    case (dp_interp)
      4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC: dp_ok = 1'b1;
      default: dp_ok = 1'b0;
    endcase
    case (ch_interp)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8: ch_ok = 1'b1;
      default: ch_ok = 1'b0;
    endcase
    link_mode_invalid = !(dp_ok && ch_ok && (st_reg.link_mode[4:0] <= `LINK_MODE_MAX));
  end

  // read decode; reserved bits read zero
  always_comb begin
    hit = 1'b1;
    rd_byte = 8'h00;
    if (paddr == `ADDR_OF(`IDX_PWR)) begin
      rd_byte = {2'h0, st_reg.aux_b, st_reg.aux_a, 3'h0, st_reg.pwr_down};
    end else if (paddr == `ADDR_OF(`IDX_CTRL)) begin
      rd_byte = {st_reg.shadow.conv_set, st_reg.shadow.search_mode,
                 st_reg.shadow.search_dir, 2'h0, st_reg.loop_en};
    end else if (paddr == `ADDR_OF(`IDX_STAT)) begin
      rd_byte = {7'h00, st_reg.lock_snap};
    end else if (paddr == `ADDR_OF(`IDX_READ)) begin
      rd_byte = {7'h00, st_reg.read_en};
    end else if (paddr == `ADDR_OF(`IDX_FINE_A)) begin
      rd_byte = {2'h0, st_reg.shadow.fine_a};
    end else if (paddr == `ADDR_OF(`IDX_FINE_B)) begin
      rd_byte = {2'h0, st_reg.shadow.fine_b};
    end else if (paddr == `ADDR_OF(`IDX_UPD)) begin
      rd_byte = {7'h00, st_reg.update};
    end else if (paddr == `ADDR_OF(`IDX_DIG)) begin
      rd_byte = {7'h00, st_reg.dig_hold};
    end else if (paddr == `ADDR_OF(`IDX_LINK)) begin
      rd_byte = {link_mode_invalid, st_reg.merge, st_reg.link_mode};
    end else begin
      hit = 1'b0;
    end
  end

  // strobe edges seen on the write itself
  assign readback_rise = wr_cyc && (paddr == `ADDR_OF(`IDX_READ)) && pwdata[0] && !st_reg.read_en;
  assign update_rise = wr_cyc && (paddr == `ADDR_OF(`IDX_UPD)) && pwdata[0] && !st_reg.update;

  // active-low requests: either link asking pulls the merged line low
  assign merged = &st_reg.sync_sync;

  // next state
  always_comb begin
    st_next = st_reg;
    // synchronisers, first stage read only by the second
    st_next.lock_meta = dll_locked;
    st_next.lock_sync = st_reg.lock_meta;
    st_next.sync_meta = link_sync_in;
    st_next.sync_sync = st_reg.sync_meta;
    // setup cycle captures read data and error
    if (setup_cyc) begin
      st_next.rdata = {24'h00_0000, rd_byte};
      st_next.err = !hit;
    end
    // register writes in the access phase
    if (wr_cyc) begin
      if (paddr == `ADDR_OF(`IDX_PWR)) begin
        st_next.pwr_down = pwdata[`PWR_DOWN_BIT];
        st_next.aux_a = pwdata[`PWR_AUX_A_BIT];
        st_next.aux_b = pwdata[`PWR_AUX_B_BIT];
      end else if (paddr == `ADDR_OF(`IDX_CTRL)) begin
        st_next.shadow.conv_set = pwdata[7:6];
        st_next.shadow.search_mode = pwdata[`CTRL_MODE_BIT];
        st_next.shadow.search_dir = pwdata[4:3];
        st_next.loop_en = pwdata[`CTRL_EN_BIT];
      end else if (paddr == `ADDR_OF(`IDX_READ)) begin
        st_next.read_en = pwdata[0];
      end else if (paddr == `ADDR_OF(`IDX_FINE_A)) begin
        st_next.shadow.fine_a = pwdata[5:0];
      end else if (paddr == `ADDR_OF(`IDX_FINE_B)) begin
        st_next.shadow.fine_b = pwdata[5:0];
      end else if (paddr == `ADDR_OF(`IDX_UPD)) begin
        st_next.update = pwdata[0];
      end else if (paddr == `ADDR_OF(`IDX_DIG)) begin
        st_next.dig_hold = pwdata[0];
      end else if (paddr == `ADDR_OF(`IDX_LINK)) begin
        st_next.merge = pwdata[`LINK_MERGE_BIT];
        st_next.link_mode = pwdata[5:0];
      end
    end
    // lock snapshot only on readback rising edge
    if (readback_rise) begin
      st_next.lock_snap = st_reg.lock_sync;
    end
    // loop settings reach the circuitry only on update rising edge
    if (update_rise) begin
      st_next.applied = st_reg.shadow;
    end
    // sync output merging in dual link
    if (st_reg.merge && st_reg.link_mode[5]) begin
      st_next.sync_out = {merged, merged};
    end else begin
      st_next.sync_out = st_reg.sync_sync;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ===========================================================================
  // outputs
  assign prdata = st_reg.rdata;
  assign pslverr = st_reg.err;
  assign delay_line_power_down = st_reg.pwr_down;
  assign delay_line_aux_power_a = st_reg.aux_a;
  assign delay_line_aux_power_b = st_reg.aux_b;
  assign loop_enable = st_reg.loop_en;
  assign loop_applied = st_reg.applied;
  assign digital_logic_hold_reset = st_reg.dig_hold;
  assign link_mode_select = '{merge: st_reg.merge, dual: st_reg.link_mode[5],
                              mode: st_reg.link_mode[4:0]};
  assign link_sync_output = st_reg.sync_out;

  // ===========================================================================
  // assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // power bit written lands on the output next cycle
  a_power_bit_write: assert property (
    wr_cyc && paddr == `ADDR_OF(`IDX_PWR)
      |=> delay_line_power_down == $past(pwdata[0]))
    else $error("delay line power bit not written");

  // enable follows the written bit
  a_loop_enable_write: assert property (
    wr_cyc && paddr == `ADDR_OF(`IDX_CTRL)
      |=> loop_enable == $past(pwdata[0]))
    else $error("loop enable not written");

  // lock snapshot captures the synchronised lock on a rising strobe
  a_lock_snapshot: assert property (
    readback_rise |=> st_reg.lock_snap == $past(st_reg.lock_sync))
    else $error("lock snapshot missed");

  // snapshot stands still without a rising strobe
  a_lock_hold: assert property (
    !readback_rise |=> $stable(st_reg.lock_snap))
    else $error("lock snapshot changed without strobe");

  // read of the status register returns the snapshot
  a_lock_readback: assert property (
    setup_cyc && paddr == `ADDR_OF(`IDX_STAT)
      |=> prdata == {31'h0000_0000, $past(st_reg.lock_snap)})
    else $error("lock status read wrong");

  // applied settings move only on a rising update
  a_update_apply: assert property (
    update_rise |=> loop_applied == $past(st_reg.shadow))
    else $error("loop settings not applied");

  a_applied_hold: assert property (
    !update_rise |=> $stable(loop_applied))
    else $error("loop settings moved without update");

  // digital reset bit drives the hold output
  a_digital_hold: assert property (
    wr_cyc && paddr == `ADDR_OF(`IDX_DIG)
      |=> digital_logic_hold_reset == $past(pwdata[0]))
    else $error("digital reset hold wrong");

  // invalid flag read back in bit 7
  a_invalid_read: assert property (
    setup_cyc && paddr == `ADDR_OF(`IDX_LINK)
      |=> prdata[7] == $past(link_mode_invalid))
    else $error("invalid flag read wrong");

  // merged outputs agree while merging stays on
  a_merge_equal: assert property (
    (st_reg.merge && st_reg.link_mode[5])[*2] |-> link_sync_output[0] == link_sync_output[1])
    else $error("sync outputs not merged");

  // link mode field drives the link selection
  a_link_mode_write: assert property (
    wr_cyc && paddr == `ADDR_OF(`IDX_LINK)
      |=> link_mode_select.dual == $past(pwdata[5]) && link_mode_select.mode == $past(pwdata[4:0]))
    else $error("link mode not written");

  // auxiliary power controls land with the main power bit
  a_aux_power_write: assert property (
    wr_cyc && paddr == `ADDR_OF(`IDX_PWR)
      |=> delay_line_aux_power_a == $past(pwdata[4]) && delay_line_aux_power_b == $past(pwdata[5]))
    else $error("auxiliary power bits not written");

  // power bit moves only on its own write
  a_power_hold: assert property (
    !(wr_cyc && paddr == `ADDR_OF(`IDX_PWR)) |=> $stable(delay_line_power_down))
    else $error("power bit changed without write");

  // enable moves only on a control write
  a_loop_enable_hold: assert property (
    !(wr_cyc && paddr == `ADDR_OF(`IDX_CTRL)) |=> $stable(loop_enable))
    else $error("loop enable changed without write");

  // control writes fill the shadow settings, not the applied ones
  a_search_fields_write: assert property (
    wr_cyc && paddr == `ADDR_OF(`IDX_CTRL)
      |=> st_reg.shadow.conv_set == $past(pwdata[7:6])
        && st_reg.shadow.search_mode == $past(pwdata[5])
        && st_reg.shadow.search_dir == $past(pwdata[4:3]))
    else $error("shadow loop settings not written");

  // hold bit moves only on its own write
  a_dig_hold_stable: assert property (
    !(wr_cyc && paddr == `ADDR_OF(`IDX_DIG)) |=> $stable(digital_logic_hold_reset))
    else $error("digital hold changed without write");

  // a mode number beyond the table always flags
  a_invalid_mode_range: assert property (
    st_reg.link_mode[4:0] > `LINK_MODE_MAX |-> link_mode_invalid)
    else $error("out of range mode not flagged");

  // merge bit reaches the link selection
  a_merge_bit_write: assert property (
    wr_cyc && paddr == `ADDR_OF(`IDX_LINK)
      |=> link_mode_select.merge == $past(pwdata[`LINK_MERGE_BIT]))
    else $error("merge bit not written");

  // any request while merging pulls both outputs low
  a_merge_low: assert property (
    st_reg.merge && st_reg.link_mode[5] && !(&st_reg.sync_sync) |=> link_sync_output == 2'b00)
    else $error("merged sync outputs not low");

  // without merging each output follows its own link
  a_sync_follow: assert property (
    !(st_reg.merge && st_reg.link_mode[5]) |=> link_sync_output == $past(st_reg.sync_sync))
    else $error("sync outputs do not follow links");

  // covers of main scenarios
  c_unmapped: cover property (setup_cyc && !hit);
  c_update: cover property (update_rise);
  c_readback: cover property (readback_rise ##1 st_reg.lock_snap);
  c_invalid: cover property (link_mode_invalid);
  c_merge: cover property (st_reg.merge && st_reg.link_mode[5] && !link_sync_output[0]);

endmodule

// File: test/test_dll_datapath_cfg.sv
// self-checking bench for the delay loop and datapath configuration bank
// assumes: dll_cfg_pkg compiled first; apb master driven here on pclk
module test_dll_datapath_cfg
  import dll_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ===========================================================================
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dll_locked = 1'b0;
  logic [3:0] dp_interp = 4'h1;
  logic [3:0] ch_interp = 4'h1;
  logic [1:0] link_sync_in = 2'b11;
  logic pd, aux_a, aux_b, loop_en, hold, inval;
  loop_cfg_t appl;
  link_cfg_t lsel;
  logic [1:0] sync_o;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int check_count = 0;
  int seed = 32'he230bca9;
  logic [7:0] m;
  logic [5:0] fa, fb;
  // ===========================================================================
  // design
  dll_datapath_cfg uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dll_locked(dll_locked), .dp_interp(dp_interp), .ch_interp(ch_interp),
    .link_sync_in(link_sync_in), .delay_line_power_down(pd), .delay_line_aux_power_a(aux_a),
    .delay_line_aux_power_b(aux_b), .loop_enable(loop_en), .loop_applied(appl),
    .digital_logic_hold_reset(hold), .link_mode_select(lsel), .link_mode_invalid(inval),
    .link_sync_output(sync_o));
  // clock at 40 MHz
  always #12.5 pclk = ~pclk;
  // ===========================================================================
  // tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  // flag of an unsupported link mode and interpolation pair
  function automatic logic exp_inv(input logic [7:0] md, input logic [3:0] d, input logic [3:0] c);
    return !((d inside {1, 2, 4, 6, 8, 12}) && (c inside {1, 2, 3, 4, 6, 8}) && md[4:0] <= 5'h16);
  endfunction
  // watchdog against a hang
  initial begin
    #500000;
    bad_count++;
    report_and_stop();
  end
  // ===========================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("pd", 1, pd);
    chk("en", 0, loop_en);
    chk("hold", 1, hold);
    chk("link", 7'h20, lsel);
    chk("appl", {2'h1, 1'b1, 2'h2, 12'h000}, appl);
    rdchk("r_pwr", 12'h300, 32'h0000_0031);
    rdchk("r_ctl", 12'h304, 32'h0000_0070);
    rdchk("r_dig", 12'h400, 32'h0000_0001);
    rdchk("r_lnk", 12'h440, 32'h0000_0020);
    $display("test reset done");
    apb(1'b1, 12'h300, 32'h0000_00f0);
    @(negedge pclk);
    chk("pd", 3'b011, {pd, aux_a, aux_b});
    apb(1'b1, 12'h300, 32'h0000_0000);
    @(negedge pclk);
    chk("pd", 3'b000, {pd, aux_a, aux_b});
    apb(1'b1, 12'h304, 32'h0000_0049);
    @(negedge pclk);
    chk("en", 1, loop_en);
    chk("hold_appl", {2'h1, 1'b1, 2'h2, 12'h000}, appl);
    rdchk("r_ctl", 12'h304, 32'h0000_0049);
    $display("test power done");
    fa = 6'($random(seed));
    fb = 6'($random(seed));
    apb(1'b1, 12'h330, {26'h0, fa} | 32'h0000_00c0);
    apb(1'b1, 12'h334, {26'h0, fb});
    rdchk("r_fa", 12'h330, {26'h0, fa});
    apb(1'b1, 12'h36c, 32'h0000_0001);
    @(negedge pclk);
    chk("appl", {2'h1, 1'b0, 2'h1, fa, fb}, appl);
    apb(1'b1, 12'h330, {26'h0, ~fa});
    apb(1'b1, 12'h36c, 32'h0000_0001);
    @(negedge pclk);
    chk("appl_hi", {2'h1, 1'b0, 2'h1, fa, fb}, appl);
    apb(1'b1, 12'h36c, 32'h0000_0000);
    apb(1'b1, 12'h36c, 32'h0000_0001);
    @(negedge pclk);
    chk("appl2", {2'h1, 1'b0, 2'h1, ~fa, fb}, appl);
    $display("test update done");
    @(posedge pclk);
    dll_locked <= 1'b1;
    repeat (4) @(posedge pclk);
    rdchk("lock0", 12'h30c, 32'h0000_0000);
    apb(1'b1, 12'h31c, 32'h0000_0001);
    rdchk("lock1", 12'h30c, 32'h0000_0001);
    dll_locked <= 1'b0;
    repeat (4) @(posedge pclk);
    rdchk("lock_hold", 12'h30c, 32'h0000_0001);
    apb(1'b1, 12'h31c, 32'h0000_0000);
    apb(1'b1, 12'h31c, 32'h0000_0001);
    rdchk("lock2", 12'h30c, 32'h0000_0000);
    apb(1'b1, 12'h400, 32'h0000_0000);
    @(negedge pclk);
    chk("hold", 0, hold);
    $display("test lock done");
    for (int i = 0; i < 24; i++) begin
      m = (i == 0) ? 8'h56 : (i == 1) ? 8'h17 : 8'($random(seed));
      @(posedge pclk);
      dp_interp <= (i < 2) ? 4'h1 : 4'($random(seed));
      ch_interp <= (i < 2) ? 4'h2 : 4'($random(seed));
      apb(1'b1, 12'h440, {24'h0, m});
      @(negedge pclk);
      chk("lsel", {m[6], m[5], m[4:0]}, lsel);
      chk("inv", exp_inv(m, dp_interp, ch_interp), inval);
      rdchk("r_lnk", 12'h440, {24'h0, exp_inv(m, dp_interp, ch_interp), m[6:0]});
      @(posedge pclk);
      dp_interp <= 4'h8;
      ch_interp <= 4'h3;
      @(negedge pclk);
      chk("inv_now", exp_inv(m, 4'h8, 4'h3), inval);
    end
    $display("test link done");
    @(posedge pclk);
    link_sync_in <= 2'b01;
    apb(1'b1, 12'h440, 32'h0000_0060);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("sync_m", 2'b00, sync_o);
    apb(1'b1, 12'h440, 32'h0000_0040);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("sync_s", 2'b01, sync_o);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("err", 1, er);
    chk("err_d", 0, rd);
    $display("test merge done");
    report_and_stop();
  end
endmodule
